// *** mhb_pkg.sv ***
// package for the multiplexed host port front end
// assumes a single 10 MHz system clock; straps are static after reset
package mhb_pkg;
	localparam int ADDR_HALF_W = 8;
	localparam int DATA_W      = 16;
	localparam int SYNC_STAGES = 2;
	localparam logic [7:0] ADDR_LO_RST = 8'h00;
	localparam logic [7:0] ADDR_HI_RST = 8'h00;
	localparam logic [15:0] DATA_RST   = 16'h0000;
	localparam int LANE_LO_MSB = 7;
	localparam int LANE_HI_LSB = 8;
	localparam int LANE_HI_MSB = 15;

	typedef enum logic [1:0] {
		MHB_IDLE  = 2'b00,
		MHB_READ  = 2'b01,
		MHB_WRITE = 2'b10
	} mhb_state_t;
endpackage

// *** mhb_sync.sv ***
// two-flop synchroniser for a group of asynchronous host pins
// assumes the clock enable gates all state
`timescale 1ns/1ps
module mhb_sync #(
	parameter int W = 1
) (
	input  wire logic         CLK,
	input  wire logic         SYS_RST,
	input  wire logic         CE,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// first stage feeds only the second stage
	always_comb begin
		meta_nxt = meta_r;
		q_nxt    = q_r;
		if (SYS_RST) begin
			meta_nxt = '0;
			q_nxt    = '0;
		end else if (CE) begin
			meta_nxt = d;
			q_nxt    = meta_r;
		end
	end

	always_ff @(posedge CLK) begin
		meta_r <= meta_nxt;
		q_r    <= q_nxt;
	end

	assign q = q_r;
endmodule

// *** mhb_host_port.sv ***
// multiplexed address/data host port front end
// assumes host pins are asynchronous and slow against the 10 MHz clock;
// straps are static; the core answers read data combinationally from ADDR
`timescale 1ns/1ps
module mhb_host_port (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic        CE,
	// straps
	input  wire logic        DUAL_PHASE_CFG,
	input  wire logic        BUS16_CFG,
	input  wire logic        STROBE_STYLE_CFG,
	input  wire logic        ADDR_STROBE_LEVEL_CFG,
	input  wire logic        SELECT_LEVEL_CFG,
	input  wire logic        READ_DIR_LEVEL_CFG,
	input  wire logic        WRITE_EN_LEVEL_CFG,
	input  wire logic        ADDR_STROBE_GATE_CFG,
	// host pins
	input  wire logic        UPPER_ADDR_STROBE,
	input  wire logic        LOWER_ADDR_STROBE,
	input  wire logic        SELECT,
	input  wire logic        READ_DIR,
	input  wire logic        WRITE_XFER_STROBE,
	input  wire logic [15:0] AD_IN,
	output logic      [15:0] AD_OUT,
	output logic      [1:0]  AD_OE,
	// core side
	output logic      [15:0] ADDR,
	output logic             RD_STB,
	output logic             WR_STB,
	output logic      [15:0] WR_DATA,
	input  wire logic [15:0] RD_DATA
);
	localparam int NSIG = 5;

	logic [NSIG-1:0] raw;
	logic [NSIG-1:0] syn;
	logic [NSIG-1:0] syn_d_r;
	logic [NSIG-1:0] syn_d_nxt;
	logic [15:0]     ad_syn;
	logic            ale_hi, ale_lo, sel, rdir, wen;
	logic            cyc_rd, cyc_wr, ale_hi_fall, ale_lo_fall;
	logic [7:0]      addr_lo_r, addr_lo_nxt, addr_hi_r, addr_hi_nxt;
	logic [15:0]     rdat_r, rdat_nxt, wdat_r, wdat_nxt;
	logic            rd_stb_r, rd_stb_nxt, wr_stb_r, wr_stb_nxt;
	mhb_pkg::mhb_state_t st_r, st_nxt;

	// every level normalised to active high by its strap
	assign raw = {UPPER_ADDR_STROBE ^ ~ADDR_STROBE_LEVEL_CFG,
		LOWER_ADDR_STROBE ^ ~ADDR_STROBE_LEVEL_CFG,
		SELECT ^ ~SELECT_LEVEL_CFG,
		READ_DIR ^ ~READ_DIR_LEVEL_CFG,
		WRITE_XFER_STROBE ^ ~WRITE_EN_LEVEL_CFG};

	// strobes and data pins through two flops before use
	mhb_sync #(.W(NSIG)) u_sync_ctl (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.CE      (CE),
		.d       (raw),
		.q       (syn)
	);
	mhb_sync #(.W(mhb_pkg::DATA_W)) u_sync_ad (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.CE      (CE),
		.d       (AD_IN),
		.q       (ad_syn)
	);

	assign ale_hi = syn[4];
	assign ale_lo = syn[3];
	assign sel    = syn[2];
	assign rdir   = syn[1];
	assign wen    = syn[0];

	// address strobe counts on its falling edge; gating by select optional
	assign ale_hi_fall = syn_d_r[4] & ~ale_hi & (~ADDR_STROBE_GATE_CFG | sel);
	assign ale_lo_fall = syn_d_r[3] & ~ale_lo & (~ADDR_STROBE_GATE_CFG | sel);

	// strobe style: separate rd/wr, or direction plus enable
	always_comb begin
		if (STROBE_STYLE_CFG) begin
			cyc_rd = sel & wen & ~rdir;
			cyc_wr = sel & wen & rdir;
		end else begin
			cyc_rd = sel & rdir;
			cyc_wr = sel & wen;
		end
	end

	// address latch; halves taken in any order, omitted ones retained
	always_comb begin
		addr_lo_nxt = addr_lo_r;
		addr_hi_nxt = addr_hi_r;
		syn_d_nxt   = syn_d_r;
		if (SYS_RST) begin
			addr_lo_nxt = mhb_pkg::ADDR_LO_RST;
			addr_hi_nxt = mhb_pkg::ADDR_HI_RST;
			syn_d_nxt   = '0;
		end else if (CE) begin
			syn_d_nxt = syn;
			if (DUAL_PHASE_CFG) begin
				// both halves from the low lane, upper lane ignored
				if (ale_lo_fall)
					addr_lo_nxt = ad_syn[mhb_pkg::LANE_LO_MSB:0];
				if (ale_hi_fall) // no strobe: upper kept
					addr_hi_nxt = ad_syn[mhb_pkg::LANE_LO_MSB:0];
			end else if (ale_lo_fall) begin
				// both lanes in one phase
				addr_lo_nxt = ad_syn[mhb_pkg::LANE_LO_MSB:0];
				addr_hi_nxt = ad_syn[mhb_pkg::LANE_HI_MSB:mhb_pkg::LANE_HI_LSB];
			end
		end
	end

	always_ff @(posedge CLK) begin
		addr_lo_r <= addr_lo_nxt;
		addr_hi_r <= addr_hi_nxt;
		syn_d_r   <= syn_d_nxt;
	end

	// data cycle machine; address not cleared so repeat access works
	always_comb begin
		st_nxt     = st_r;
		rdat_nxt   = rdat_r;
		wdat_nxt   = wdat_r;
		rd_stb_nxt = 1'b0;
		wr_stb_nxt = 1'b0;
		if (SYS_RST) begin
			st_nxt   = mhb_pkg::MHB_IDLE;
			rdat_nxt = mhb_pkg::DATA_RST;
			wdat_nxt = mhb_pkg::DATA_RST;
		end else if (CE) begin
			unique case (st_r)
				mhb_pkg::MHB_IDLE: begin
					if (cyc_rd) begin
						st_nxt   = mhb_pkg::MHB_READ;
						rdat_nxt = RD_DATA; // held for the whole read
					end else if (cyc_wr) begin
						st_nxt = mhb_pkg::MHB_WRITE;
					end
				end
				mhb_pkg::MHB_READ: begin
					if (!cyc_rd) begin
						st_nxt     = mhb_pkg::MHB_IDLE;
						rd_stb_nxt = 1'b1; // core advances at read end
					end
				end
				mhb_pkg::MHB_WRITE: begin
					if (cyc_wr) begin
						wdat_nxt = ad_syn; // last sample before release wins
					end else begin
						st_nxt     = mhb_pkg::MHB_IDLE;
						wr_stb_nxt = 1'b1;
					end
				end
				default: st_nxt = mhb_pkg::MHB_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		st_r     <= st_nxt;
		rdat_r   <= rdat_nxt;
		wdat_r   <= wdat_nxt;
		rd_stb_r <= rd_stb_nxt;
		wr_stb_r <= wr_stb_nxt;
	end

	assign ADDR    = {addr_hi_r, addr_lo_r};
	assign RD_STB  = rd_stb_r;
	assign WR_STB  = wr_stb_r;
	// 8-bit mode keeps only the low byte of a write
	assign WR_DATA = BUS16_CFG ? wdat_r : {8'h00, wdat_r[mhb_pkg::LANE_LO_MSB:0]};
	assign AD_OUT  = rdat_r;
	// upper lane driven only for 16-bit reads
	assign AD_OE   = {(st_r == mhb_pkg::MHB_READ) & BUS16_CFG,
		st_r == mhb_pkg::MHB_READ};

	// assertions
	property p_hi_lane_quiet;
		@(posedge CLK) disable iff (SYS_RST)
		!BUS16_CFG |-> !AD_OE[1];
	endproperty
	a_hi_lane_quiet: assert property (p_hi_lane_quiet) else $error("upper lane driven");

	property p_no_drive_idle;
		@(posedge CLK) disable iff (SYS_RST)
		($past(CE) && $past(st_r) == mhb_pkg::MHB_IDLE && !$past(cyc_rd)) |-> (AD_OE == 2'b00);
	endproperty
	a_no_drive_idle: assert property (p_no_drive_idle) else $error("drive outside read");

	property p_hi_kept;
		@(posedge CLK) disable iff (SYS_RST)
		(CE && DUAL_PHASE_CFG && !ale_hi_fall) |=> $stable(addr_hi_r);
	endproperty
	a_hi_kept: assert property (p_hi_kept) else $error("upper half changed");

	property p_lo_kept;
		@(posedge CLK) disable iff (SYS_RST)
		(CE && !ale_lo_fall) |=> $stable(addr_lo_r);
	endproperty
	a_lo_kept: assert property (p_lo_kept) else $error("lower half changed");

	property p_dual_lo_lane;
		@(posedge CLK) disable iff (SYS_RST)
		(CE && DUAL_PHASE_CFG && ale_hi_fall) |=> addr_hi_r == $past(ad_syn[mhb_pkg::LANE_LO_MSB:0]);
	endproperty
	a_dual_lo_lane: assert property (p_dual_lo_lane) else $error("upper from wrong lane");

	property p_single;
		@(posedge CLK) disable iff (SYS_RST)
		(CE && !DUAL_PHASE_CFG && ale_lo_fall) |=> ADDR == $past(ad_syn);
	endproperty
	a_single: assert property (p_single) else $error("single phase latch");

	sequence s_read_end;
		(st_r == mhb_pkg::MHB_READ) ##1 (st_r == mhb_pkg::MHB_IDLE);
	endsequence
	property p_rd_stb;
		@(posedge CLK) disable iff (SYS_RST)
		s_read_end |-> RD_STB;
	endproperty
	a_rd_stb: assert property (p_rd_stb) else $error("missing read strobe");

	property p_wr_dir;
		@(posedge CLK) disable iff (SYS_RST)
		(CE && STROBE_STYLE_CFG && st_r == mhb_pkg::MHB_IDLE && sel && wen && !rdir)
		|=> st_r == mhb_pkg::MHB_READ;
	endproperty
	a_wr_dir: assert property (p_wr_dir) else $error("direction low not read");

	// write end mirrors read end: one pulse as the machine drops back
	// the core must see exactly one commit per host write
	sequence s_write_end;
		(st_r == mhb_pkg::MHB_WRITE) ##1 (st_r == mhb_pkg::MHB_IDLE);
	endsequence
	property p_wr_stb;
		@(posedge CLK) disable iff (SYS_RST)
		s_write_end |-> WR_STB;
	endproperty
	a_wr_stb: assert property (p_wr_stb) else $error("missing write strobe");

	// separate strobe style: read strobe alone opens a read
	property p_sep_rd;
		@(posedge CLK) disable iff (SYS_RST)
		(CE && !STROBE_STYLE_CFG && st_r == mhb_pkg::MHB_IDLE && sel && rdir)
		|=> st_r == mhb_pkg::MHB_READ;
	endproperty
	a_sep_rd: assert property (p_sep_rd) else $error("read strobe not taken");

	// gated strobes: nothing latched while select is idle
	property p_gate_refuse;
		@(posedge CLK) disable iff (SYS_RST)
		(CE && ADDR_STROBE_GATE_CFG && !sel) |=> $stable(ADDR);
	endproperty
	a_gate_refuse: assert property (p_gate_refuse) else $error("ungated address latch");

	// read data frozen for the whole read so a live core value cannot tear
	// across the host's sampling window
	property p_rd_hold;
		@(posedge CLK) disable iff (SYS_RST)
		(st_r == mhb_pkg::MHB_READ && $past(st_r) == mhb_pkg::MHB_READ)
		|-> $stable(AD_OUT);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

	// clock enable low: address and machine hold still
	// strobe pulses are events, not state, and may end while frozen
	property p_ce_hold;
		@(posedge CLK) disable iff (SYS_RST)
		!CE |=> ($stable(ADDR) && $stable(st_r) && $stable(AD_OE));
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");

	// 8-bit writes never pass the upper lane to the core
	property p_byte_wr;
		@(posedge CLK) disable iff (SYS_RST)
		!BUS16_CFG |-> WR_DATA[mhb_pkg::LANE_HI_MSB:mhb_pkg::LANE_HI_LSB] == 8'h00;
	endproperty
	a_byte_wr: assert property (p_byte_wr) else $error("upper byte passed");
endmodule

// *** mhb_host_model.sv ***
// host microcontroller model driving the multiplexed pins
// assumes the bench calls its tasks; pins change only at falling edges
`timescale 1ns/1ps
module mhb_host_model (
	input  wire logic        clk,
	input  wire logic        style,
	input  wire logic        lvl,
	output logic             upper_addr_strobe,
	output logic             lower_addr_strobe,
	output logic             select,
	output logic             read_dir,
	output logic             xfer_strobe,
	output logic      [15:0] ad,
	input  wire logic [15:0] wire_ad,
	input  wire logic [1:0]  oe
);
	logic a_hi = 1'h0, a_lo = 1'h0, a_sel = 1'h0, a_rd = 1'h0, a_wr = 1'h0, a_dir = 1'h0;

	// active flags mapped onto the strap levels
	assign upper_addr_strobe = a_hi ~^ lvl;
	assign lower_addr_strobe = a_lo ~^ lvl;
	assign select            = a_sel ~^ lvl;
	assign read_dir          = (style ? a_dir : a_rd) ~^ lvl;
	assign xfer_strobe       = (style ? (a_rd | a_wr) : a_wr) ~^ lvl;
	initial ad = 16'h0000;

	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask

	// select held two cycles past the strobe so a gated fall survives a frozen sample;
	// lines flip so stale data never looks valid
	task automatic strobe(input logic hi, input logic sel, input logic [15:0] v);
		@(negedge clk);
		ad = v;
		a_sel = sel;
		a_hi = hi;
		a_lo = !hi;
		gap(4);
		a_hi = 1'h0;
		a_lo = 1'h0;
		gap(2);
		a_sel = 1'h0;
		gap(1);
		ad = ~v;
		gap(3);
	endtask

	// direction set a cycle before enable and kept a cycle after
	task automatic wr(input logic [15:0] d);
		@(negedge clk);
		ad = d;
		a_sel = 1'h1;
		a_dir = 1'h1;
		gap(1);
		a_wr = 1'h1;
		gap(4);
		a_wr = 1'h0;
		gap(1);
		a_sel = 1'h0;
		a_dir = 1'h0;
		gap(1);
		ad = ~d;
		gap(3);
	endtask

	// host lines stay released while the device answers
	task automatic rd(output logic [15:0] q, output logic [1:0] o);
		@(negedge clk);
		a_sel = 1'h1;
		a_rd = 1'h1;
		gap(6);
		q = wire_ad;
		o = oe;
		a_rd = 1'h0;
		gap(1);
		a_sel = 1'h0;
		gap(4);
	endtask
endmodule

// *** mhb_host_port_tb.sv ***
// self-checking bench for the multiplexed host port
// assumes the host model file is compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module mhb_host_port_tb;
	logic        clk = 1'h0, rst = 1'h1, dual, b16, sty, lvl, gate;
	logic [15:0] rdd = 16'h0000, host_ad, wire_ad, ad_out, addr, wr_data, q, a, d;
	logic [1:0]  ad_oe, o;
	logic        ce = 1'h1;
	logic [2:0]  ce_cnt = 3'h0;
	logic        ua, la, sel, rdir, xs, rd_stb, wr_stb;
	logic [32:0] expq[$];
	int          failures = 0, n_tests = 0;

	initial forever #50 clk = ~clk;
	// enable dropped one cycle in eight; regular so host pulses keep enough samples
	always @(negedge clk) begin
		ce_cnt <= ce_cnt + 3'h1;
		ce     <= ce_cnt != 3'h7;
	end
	// wire level from the device's enables; host value where the device is not driving
	assign wire_ad = {ad_oe[1] ? ad_out[15:8] : host_ad[15:8], ad_oe[0] ? ad_out[7:0] : host_ad[7:0]};

	mhb_host_port mhb_host_port_i (.CLK(clk), .SYS_RST(rst), .CE(ce), .DUAL_PHASE_CFG(dual),
		.BUS16_CFG(b16), .STROBE_STYLE_CFG(sty), .ADDR_STROBE_LEVEL_CFG(lvl),
		.SELECT_LEVEL_CFG(lvl), .READ_DIR_LEVEL_CFG(lvl), .WRITE_EN_LEVEL_CFG(lvl),
		.ADDR_STROBE_GATE_CFG(gate), .UPPER_ADDR_STROBE(ua), .LOWER_ADDR_STROBE(la),
		.SELECT(sel), .READ_DIR(rdir), .WRITE_XFER_STROBE(xs), .AD_IN(wire_ad), .AD_OUT(ad_out),
		.AD_OE(ad_oe), .ADDR(addr), .RD_STB(rd_stb), .WR_STB(wr_stb), .WR_DATA(wr_data),
		.RD_DATA(rdd));
	mhb_host_model host (.clk(clk), .style(sty), .lvl(lvl), .upper_addr_strobe(ua),
		.lower_addr_strobe(la), .select(sel), .read_dir(rdir), .xfer_strobe(xs), .ad(host_ad),
		.wire_ad(wire_ad), .oe(ad_oe));

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// oldest note taken whenever the core side sees a transfer end
	always @(negedge clk) begin
		logic [32:0] e;
		if (rd_stb === 1'h1 || wr_stb === 1'h1) begin
			e = (expq.size() > 0) ? expq.pop_front() : 'x;
			`CHK(wr_stb, e[32])
			`CHK(addr, e[31:16])
			if (e[32]) `CHK(wr_data, e[15:0])
		end
	end

	// one host transfer; reads are also checked on the wire
	task automatic op(input logic w);
		d = 16'($urandom);
		if (w) begin
			expq.push_back({1'h1, a, b16 ? d : {8'h00, d[7:0]}});
			host.wr(d);
		end else begin
			rdd = d;
			expq.push_back({1'h0, a, 16'h0000});
			host.rd(q, o);
			`CHK(o, b16 ? 2'h3 : 2'h1)
			`CHK(b16 ? q : {8'h00, q[7:0]}, b16 ? d : {8'h00, d[7:0]})
		end
	endtask

	// all 16 combinations of dual, b16, sty and lvl (gate follows lvl): latch, mixed transfers, lower-only update, gated strobe
	initial begin
		void'($urandom(32'hD1021006));
		{dual, b16, sty, lvl, gate} = 5'h00;
		for (int m = 0; m < 16; m++) begin
			{lvl, sty, b16, dual} = 4'(m);
			gate = lvl;
			rst = 1'h1;
			repeat (3) @(negedge clk);
			rst = 1'h0;
			a = 16'($urandom);
			if (!dual) host.strobe(1'h0, 1'h1, a);
			else if (sty) begin
				host.strobe(1'h0, 1'h1, {8'($urandom), a[7:0]});
				host.strobe(1'h1, 1'h1, {8'($urandom), a[15:8]});
			end else begin
				host.strobe(1'h1, 1'h1, {8'($urandom), a[15:8]});
				host.strobe(1'h0, 1'h1, {8'($urandom), a[7:0]});
			end
			`CHK(ad_oe, 2'h0)
			for (int j = 0; j < 5; j++) op(j == 0 || j > 2);
			a[7:0] = a[7:0] ^ (b16 ? 8'h02 : 8'h01);
			host.strobe(1'h0, 1'h1, {dual ? 8'($urandom) : a[15:8], a[7:0]});
			if (gate) host.strobe(1'h0, 1'h0, 16'($urandom));
			op(1'h0);
			op(1'h1);
			$display("test mode %0d done", m);
		end
		repeat (20) @(negedge clk);
		`CHK(expq.size(), 0)
		conclude();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude();
	end
endmodule
